/* dv/sarsr_host.sv */
// host spi controller model driving select and serial clock
`timescale 1ns/1ps
`default_nettype none

module sarsr_host (
	output logic o_sclk,
	output logic o_sel_n,
	input wire logic i_dout,
	input wire logic i_dout_oe_n
);
	logic line;
	logic last;
	// released line has no pull, so show the inverse of the last bit
	assign line = i_dout_oe_n ? ~last : i_dout;
	always @(i_dout or i_dout_oe_n) begin
		if (!i_dout_oe_n) begin
			last = i_dout;
		end
	end
	initial begin
		o_sclk = 1'b0;
		o_sel_n = 1'b0;
		last = 1'b0;
	end
	task automatic frame(input int n, input int half, input logic idle,
		output logic [31:0] rx, output logic [31:0] en);
		rx = '0;
		en = '0;
		o_sclk = idle;
		#40.3;
		o_sel_n = 1'b0;
		#40;
		// idle level sets mode, sample on rising edge
		for (int i = 0; i < 2 * n; i++) begin
			o_sclk = ~o_sclk;
			if (o_sclk) begin
				rx[i / 2] = line;
				en[i / 2] = !i_dout_oe_n;
			end
			#half;
		end
		o_sel_n = 1'b1;
		// whole number of system clocks per frame, so link edges never drift onto its edge
		#299.7;
	endtask : frame
endmodule : sarsr_host

`default_nettype wire

/* dv/sarsr_readout_chk.sv */
// concurrent checks on the readout block ports
`timescale 1ns/1ps
`default_nettype none

module sarsr_readout_chk (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_sclk,
	input wire logic i_select_and_standby_n,
	input wire sarsr_pkg::sarsr_vin_t i_vin_level,
	input wire logic i_vin_valid,
	input wire logic o_vin_ready,
	input wire logic o_dout,
	input wire logic o_dout_oe_n,
	input wire logic o_standby,
	input wire logic o_hold_late
);
	import sarsr_pkg::*;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);
	// ----
	// link side, then system side
	// ----
	property p_idle_hiz;
		i_select_and_standby_n |-> o_dout_oe_n && !o_dout;
	endproperty
	a_idle_hiz: assert property (p_idle_hiz) else $error("line driven while deselected");
	property p_dout_edge;
		!i_select_and_standby_n && $changed(o_dout) |-> $fell(i_sclk);
	endproperty
	a_dout_edge: assert property (p_dout_edge) else $error("data moved off falling edge");
	property p_oe_edge;
		!i_select_and_standby_n && $changed(o_dout_oe_n) |-> $fell(i_sclk);
	endproperty
	a_oe_edge: assert property (p_oe_edge) else $error("enable moved off falling edge");
	property p_null;
		$fell(o_dout_oe_n) |-> !o_dout;
	endproperty
	a_null: assert property (p_null) else $error("first driven bit not low");
	property p_acq;
		$fell(i_select_and_standby_n) |-> o_dout_oe_n [*8];
	endproperty
	a_acq: assert property (p_acq) else $error("driven during sampling");
	// standby slow because select crosses a synchroniser
	property p_standby;
		i_select_and_standby_n [*6] |-> o_standby;
	endproperty
	a_standby: assert property (p_standby) else $error("no standby with select high");
	property p_rst;
		$fell(i_rst) |-> o_standby && !o_hold_late ##[0:1] o_vin_ready;
	endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
	property p_hold_set;
		$rose(o_hold_late) |-> !o_standby;
	endproperty
	a_hold_set: assert property (p_hold_set) else $error("late flag set in standby");
	property p_hold_clr;
		$fell(o_standby) |-> ##[0:2] !o_hold_late;
	endproperty
	a_hold_clr: assert property (p_hold_clr) else $error("late flag kept at frame start");
	c_null: cover property ($fell(o_dout_oe_n));
	c_late: cover property ($rose(o_hold_late));
	c_full: cover property (i_vin_valid && !o_vin_ready);
endmodule : sarsr_readout_chk

bind sarsr_readout sarsr_readout_chk u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_sclk(i_sclk),
	.i_select_and_standby_n(i_select_and_standby_n), .i_vin_level(i_vin_level),
	.i_vin_valid(i_vin_valid), .o_vin_ready(o_vin_ready), .o_dout(o_dout),
	.o_dout_oe_n(o_dout_oe_n), .o_standby(o_standby), .o_hold_late(o_hold_late));

`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the sar readout block
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import sarsr_pkg::*;
	localparam int HOLD = 300;
	logic clk;
	logic rst;
	logic sclk;
	logic sel_n;
	sarsr_vin_t lvl;
	logic vld;
	logic rdy;
	logic dout;
	logic oe_n;
	logic stby;
	logic late;
	int error_cnt;
	int n_tests;
	sarsr_readout #(.HOLD_LIMIT_CYCLES(HOLD)) DUT (.i_clock(clk), .i_rst(rst), .i_sclk(sclk),
		.i_select_and_standby_n(sel_n), .i_vin_level(lvl), .i_vin_valid(vld),
		.o_vin_ready(rdy), .o_dout(dout), .o_dout_oe_n(oe_n), .o_standby(stby),
		.o_hold_late(late));
	sarsr_host u_host (.o_sclk(sclk), .o_sel_n(sel_n), .i_dout(dout), .i_dout_oe_n(oe_n));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ----
	// helpers
	// ----
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	function automatic logic [9:0] clampc(input int l);
		return (l <= 0) ? 10'h000 : (l >= 1023) ? 10'h3ff : 10'(l);
	endfunction : clampc
	function automatic logic bitx(input logic [9:0] c, input int f);
		if (f >= 3 && f <= 12) return c[12 - f];
		if (f >= 13 && f <= 21) return c[f - 12];
		return 1'b0;
	endfunction : bitx
	// vld stays high on return so the caller drops it; a back to back push would resend the old level
	task automatic push(input int level);
		int k;
		k = 0;
		@(posedge clk);
		#1;
		lvl = sarsr_vin_t'(level);
		vld = 1'b1;
		while (rdy !== 1'b1 && k < 50) begin
			@(posedge clk);
			#1;
			k++;
		end
		@(posedge clk);
		#1;
		check("push accepted", k < 50, 1'b1);
		if (k >= 50) begin
			tally_and_finish;
		end
	endtask : push
	task automatic rd(input logic [9:0] c, input int n, input logic idle, input int half);
		logic [31:0] rx;
		logic [31:0] en;
		logic [15:0] w;
		w = '0;
		u_host.frame(n, half, idle, rx, en);
		for (int k = 0; k < n; k++) begin
			check("dout enable", en[k], k >= 2);
			if (k >= 2) check("dout bit", rx[k], bitx(c, k));
			if (k < 16) w = {w[14:0], rx[k]};
		end
		if (n >= 16) check("two byte value", w[12:3], c);
		check("released line", oe_n, 1'b1);
	endtask : rd
	// ----
	// scenarios
	// ----
	task automatic t_powerup;
		logic [31:0] rx;
		logic [31:0] en;
		check("standby after reset", stby, 1'b1);
		u_host.frame(16, 32, 1'b0, rx, en);
		check("no frame without high-low", en, 32'h0);
	endtask : t_powerup
	task automatic t_codes;
		int lv[6] = '{-5, 0, 1, 677, 1023, 1500};
		foreach (lv[i]) begin
			push(lv[i]);
			vld = 1'b0;
			// saturation and plain binary, both modes
			rd(clampc(lv[i]), 24, i[0], 32);
		end
	endtask : t_codes
	task automatic t_abort;
		push(300);
		vld = 1'b0;
		// partial read of eight msbs then a fresh cycle
		rd(clampc(300), 11, 1'b0, 32);
		push(600);
		vld = 1'b0;
		rd(clampc(600), 24, 1'b1, 32);
	endtask : t_abort
	task automatic t_fifo;
		int acc;
		logic ok;
		acc = 0;
		@(posedge clk);
		#1;
		vld = 1'b1;
		lvl = sarsr_vin_t'(100);
		for (int i = 0; i < 14; i++) begin
			ok = rdy;
			@(posedge clk);
			#1;
			if (ok) acc++;
			lvl = sarsr_vin_t'(100 + acc);
		end
		check("full buffer refuses", rdy, 1'b0);
		vld = 1'b0;
		// eight buffered plus one parked in the tracking node
		check("words held", acc, 9);
		for (int i = 0; i < acc; i++) rd(clampc(100 + i), 12, 1'b0, 32);
		rd(clampc(100 + acc - 1), 12, 1'b1, 32);
		check("space after drain", rdy, 1'b1);
	endtask : t_fifo
	task automatic t_hold;
		push(50);
		vld = 1'b0;
		rd(clampc(50), 16, 1'b0, 32);
		check("hold ok", late, 1'b0);
		push(51);
		vld = 1'b0;
		rd(clampc(51), 16, 1'b0, 64);
		check("hold late", late, 1'b1);
		rd(clampc(51), 16, 1'b1, 32);
		check("hold cleared", late, 1'b0);
	endtask : t_hold
	initial begin
		error_cnt = 0;
		n_tests = 0;
		rst = 1'b1;
		vld = 1'b0;
		lvl = '0;
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		t_powerup;
		t_codes;
		t_abort;
		t_fifo;
		t_hold;
		tally_and_finish;
	end
	initial begin
		#300000;
		error_cnt++;
		tally_and_finish;
	end
endmodule : testbench

`default_nettype wire

/* hw/sarsr_defs.svh */
// timing counts, field positions and limits for the sar adc serial readout
`ifndef SARSR_DEFS_SVH
`define SARSR_DEFS_SVH

// result and input word widths
`define SARSR_RES_BITS 10
`define SARSR_VIN_BITS 12

// output code saturation limits
`define SARSR_CODE_MIN 10'h000
`define SARSR_CODE_MAX 10'h3ff
`define SARSR_LEVEL_MIN 12'sh000
`define SARSR_LEVEL_MAX 12'sh3ff

// bit positions within the serial sequence
`define SARSR_MSB_IDX 4'h9
`define SARSR_LSB_IDX 4'h0
`define SARSR_LSB_FIRST_START 4'h1
`define SARSR_HOLD_CHECK_IDX 4'h2

// input buffer
`define SARSR_FIFO_DEPTH 8

// sample hold limits, times in ns, system clock period in ns
`define SARSR_CLK_PERIOD_NS 4
`define SARSR_HOLD_TIME_NS_2V7 700000
`define SARSR_HOLD_TIME_NS_5V 1500000
`define SARSR_HOLD_CYCLES_2V7 (`SARSR_HOLD_TIME_NS_2V7 / `SARSR_CLK_PERIOD_NS)
`define SARSR_HOLD_CYCLES_5V (`SARSR_HOLD_TIME_NS_5V / `SARSR_CLK_PERIOD_NS)
`define SARSR_TIMER_BITS 20

`endif

/* hw/sarsr_fifo.sv */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sarsr_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	input wire logic i_clock,
	input wire logic i_rst,
	sarsr_stream_if.snk s_in,
	sarsr_stream_if.src s_out
);
	import sarsr_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic space_q;
	logic avail_q;
	logic push;
	logic pop;

	assign push = s_in.valid & space_q;
	assign pop = s_out.ready & avail_q;
	assign s_in.ready = space_q;
	assign s_out.valid = avail_q;
	assign s_out.data = mem_q[rd_ptr_q];

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_q[wr_ptr_q] <= s_in.data;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
			end
		end
	end

	// flags registered so s_in.ready and s_out.valid both come straight from flops
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			cnt_q <= '0;
			space_q <= 1'b0;
			avail_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			space_q <= (cnt_d != FULL_CNT);
			avail_q <= (cnt_d != '0);
		end
	end

endmodule : sarsr_fifo

`default_nettype wire

/* hw/sarsr_pkg.sv */
// types shared by the sar adc serial readout modules
`include "sarsr_defs.svh"

package sarsr_pkg;

	typedef logic [`SARSR_RES_BITS-1:0] sarsr_code_t;
	typedef logic signed [`SARSR_VIN_BITS-1:0] sarsr_vin_t;
	typedef logic [3:0] sarsr_bitidx_t;

	typedef enum logic [1:0] {
		SARSR_PH_ACQ = 2'b00,
		SARSR_PH_MSB = 2'b01,
		SARSR_PH_LSB = 2'b10,
		SARSR_PH_ZERO = 2'b11
	} sarsr_phase_e;

endpackage : sarsr_pkg

/* hw/sarsr_readout.sv */
// serial readout and conversion sequencing for a 10-bit sar converter
`timescale 1ns/1ps
`default_nettype none
`include "sarsr_defs.svh"

module sarsr_readout #(
	parameter int unsigned HOLD_LIMIT_CYCLES = `SARSR_HOLD_CYCLES_5V
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_sclk,
	input wire logic i_select_and_standby_n,
	input wire sarsr_pkg::sarsr_vin_t i_vin_level,
	input wire logic i_vin_valid,
	output logic o_vin_ready,
	output logic o_dout,
	output logic o_dout_oe_n,
	output logic o_standby,
	output logic o_hold_late
);
	import sarsr_pkg::*;

	localparam logic [`SARSR_TIMER_BITS-1:0] HOLD_LIMIT = `SARSR_TIMER_BITS'(HOLD_LIMIT_CYCLES);

	// ------------------------------------------------------------
	// system domain: select pin synchroniser
	// ------------------------------------------------------------
	logic sel_s1_q;
	logic sel_s2_q;
	logic sel_s3_q;
	logic sel_level_q;
	logic sel_level_prev_q;
	logic armed_q;
	logic frame_start;
	logic standby_q;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sel_s1_q <= 1'b0;
			sel_s2_q <= 1'b0;
			sel_s3_q <= 1'b0;
		end else begin
			sel_s1_q <= i_select_and_standby_n;
			sel_s2_q <= sel_s1_q;
			sel_s3_q <= sel_s2_q;
		end
	end

	// a change counts only once two stages agree
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sel_level_q <= 1'b0;
			sel_level_prev_q <= 1'b0;
		end else begin
			if (sel_s2_q == sel_s3_q) begin
				sel_level_q <= sel_s3_q;
			end
			sel_level_prev_q <= sel_level_q;
		end
	end

	// arm on high select
	// a select held low through reset never arms the link logic
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			armed_q <= 1'b0;
		end else if (sel_level_q) begin
			armed_q <= 1'b1;
		end
	end

	assign frame_start = armed_q & sel_level_prev_q & ~sel_level_q;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			standby_q <= 1'b1;
		end else begin
			standby_q <= sel_level_q | ~armed_q;
		end
	end

	// ------------------------------------------------------------
	// system domain: input saturation and buffering
	// ------------------------------------------------------------
	sarsr_stream_if in_stream ();
	sarsr_stream_if out_stream ();
	sarsr_code_t sat_code;

	always_comb begin
		if (i_vin_level <= `SARSR_LEVEL_MIN) begin
			sat_code = `SARSR_CODE_MIN;
		end else if (i_vin_level >= `SARSR_LEVEL_MAX) begin
			sat_code = `SARSR_CODE_MAX;
		end else begin
			sat_code = i_vin_level[`SARSR_RES_BITS-1:0];
		end
	end

	assign in_stream.valid = i_vin_valid;
	assign in_stream.data = sat_code;
	assign o_vin_ready = in_stream.ready;

	sarsr_fifo #(
		.WIDTH(`SARSR_RES_BITS),
		.DEPTH(`SARSR_FIFO_DEPTH)
	) u_fifo (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.s_in(in_stream.snk),
		.s_out(out_stream.src)
	);

	// ------------------------------------------------------------
	// system domain: tracked input node
	// ------------------------------------------------------------
	// one buffered word is consumed per conversion, loaded only in standby.
	// the link reads track_q on the second falling sclk edge after sampling begins; the word is
	// frozen by then because loading stops a few system cycles after the fall.
	sarsr_code_t track_q;
	logic fresh_q;
	logic take;

	assign take = out_stream.valid & ~fresh_q & sel_level_q;
	assign out_stream.ready = take;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			track_q <= `SARSR_CODE_MIN;
		end else if (take) begin
			track_q <= out_stream.data;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			fresh_q <= 1'b0;
		end else if (frame_start) begin
			fresh_q <= 1'b0;
		end else if (take) begin
			fresh_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// link domain: reset and acquisition start
	// ------------------------------------------------------------
	logic link_rst;
	logic started_q;
	logic fall_seen_q;
	sarsr_phase_e phase_q;
	sarsr_bitidx_t bit_q;
	sarsr_code_t hold_q;
	sarsr_code_t sar_q;
	sarsr_code_t trial;
	logic cmp_bit;
	logic hold_ok_q;
	logic dout_q;
	logic oe_n_q;

	// select high aborts
	// sclk may stop while select is high, so the abort must be asynchronous
	assign link_rst = i_select_and_standby_n | ~armed_q;

	// sampling begins
	// in mode 1,1 the falling edge before this one is ignored
	always_ff @(posedge i_sclk or posedge link_rst) begin
		if (link_rst) begin
			started_q <= 1'b0;
		end else begin
			started_q <= 1'b1;
		end
	end

	always_ff @(negedge i_sclk or posedge link_rst) begin
		if (link_rst) begin
			fall_seen_q <= 1'b0;
		end else if (started_q) begin
			fall_seen_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// link domain: sequence state machine
	// ------------------------------------------------------------
	always_ff @(negedge i_sclk or posedge link_rst) begin
		if (link_rst) begin
			phase_q <= SARSR_PH_ACQ;
			bit_q <= `SARSR_MSB_IDX;
		end else if (started_q) begin
			case (phase_q)
				SARSR_PH_ACQ: begin
					if (fall_seen_q) begin
						phase_q <= SARSR_PH_MSB;
						bit_q <= `SARSR_MSB_IDX;
					end
				end
				SARSR_PH_MSB: begin
					if (bit_q == `SARSR_LSB_IDX) begin
						phase_q <= SARSR_PH_LSB;
						bit_q <= `SARSR_LSB_FIRST_START;
					end else begin
						bit_q <= bit_q - 1'b1;
					end
				end
				SARSR_PH_LSB: begin
					if (bit_q == `SARSR_MSB_IDX) begin
						phase_q <= SARSR_PH_ZERO;
					end else begin
						bit_q <= bit_q + 1'b1;
					end
				end
				SARSR_PH_ZERO: begin
					phase_q <= SARSR_PH_ZERO;
				end
				default: begin
					phase_q <= SARSR_PH_ACQ;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// link domain: sample hold and successive approximation
	// ------------------------------------------------------------
	// switch opens after 1.5 clocks
	always_ff @(negedge i_sclk or posedge link_rst) begin
		if (link_rst) begin
			hold_q <= `SARSR_CODE_MIN;
		end else if (started_q && phase_q == SARSR_PH_ACQ && fall_seen_q) begin
			hold_q <= track_q;
		end
	end

	always_comb begin
		trial = sar_q | (`SARSR_RES_BITS'(1) << bit_q);
		cmp_bit = (hold_q >= trial);
	end

	always_ff @(negedge i_sclk or posedge link_rst) begin
		if (link_rst) begin
			sar_q <= `SARSR_CODE_MIN;
		end else if (started_q && phase_q == SARSR_PH_MSB && cmp_bit) begin
			sar_q <= trial;
		end
	end

	// marks the falling edge of clock fourteen for the hold monitor
	always_ff @(negedge i_sclk or posedge link_rst) begin
		if (link_rst) begin
			hold_ok_q <= 1'b0;
		end else if (phase_q == SARSR_PH_LSB && bit_q == `SARSR_HOLD_CHECK_IDX) begin
			hold_ok_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// link domain: serial output pin
	// ------------------------------------------------------------
	// falling edge only
	always_ff @(negedge i_sclk or posedge link_rst) begin
		if (link_rst) begin
			dout_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else if (started_q) begin
			case (phase_q)
				SARSR_PH_ACQ: begin
					if (fall_seen_q) begin
						dout_q <= 1'b0;
						oe_n_q <= 1'b0;
					end
				end
				SARSR_PH_MSB: begin
					dout_q <= cmp_bit;
				end
				SARSR_PH_LSB: begin
					dout_q <= sar_q[bit_q];
				end
				SARSR_PH_ZERO: begin
					dout_q <= 1'b0;
				end
				default: begin
					dout_q <= 1'b0;
				end
			endcase
		end
	end

	assign o_dout = dout_q;
	assign o_dout_oe_n = oe_n_q;

	// ------------------------------------------------------------
	// system domain: sample hold-time monitor
	// ------------------------------------------------------------
	logic hok_s1_q;
	logic hok_s2_q;
	logic hok_s3_q;
	logic [`SARSR_TIMER_BITS-1:0] timer_q;
	logic late_q;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			hok_s1_q <= 1'b0;
			hok_s2_q <= 1'b0;
			hok_s3_q <= 1'b0;
		end else begin
			// fall fourteen counts once the last two stages agree
			hok_s1_q <= hold_ok_q;
			hok_s2_q <= hok_s1_q;
			hok_s3_q <= hok_s2_q;
		end
	end

	// watch the slow host
	// flags a frame whose first fourteen clocks outlast the held charge
	always_ff @(posedge i_clock) begin
		if (i_rst || frame_start || standby_q) begin
			timer_q <= '0;
		end else if (!(hok_s2_q && hok_s3_q) && timer_q != HOLD_LIMIT) begin
			timer_q <= timer_q + 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst || frame_start) begin
			late_q <= 1'b0;
		end else if (!standby_q && !(hok_s2_q && hok_s3_q) && timer_q == HOLD_LIMIT) begin
			late_q <= 1'b1;
		end
	end

	assign o_standby = standby_q;
	assign o_hold_late = late_q;

endmodule : sarsr_readout

`default_nettype wire

/* hw/sarsr_stream_if.sv */
// valid/ready stream carrying conversion codes between internal blocks
`timescale 1ns/1ps
`default_nettype none

interface sarsr_stream_if;
	import sarsr_pkg::*;
	logic valid;
	logic ready;
	sarsr_code_t data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : sarsr_stream_if

`default_nettype wire

/* hw/sarsr_unused_none.sv */
// intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
